// File: mqc_params.svh
// constants for the message queue control block
// Notes on behaviour
// - writable 12-bit base at control bits 31:20
// - size code selects 256..64K entries each
// - entries are words; memory is four queues
// - per-queue empty flags, read-only, reset one
// - per-queue full flags, read-only, reset zero
// - option clear: bottom read returns real pointer
// - access bit set: port writes dropped, port reads ones
// - free top register shows base read-only
// - device pointers step four, wrap at size
`ifndef MQC_PARAMS_SVH
`define MQC_PARAMS_SVH
`define MQC_OFS_CTRL      12'h200
`define MQC_OFS_PTR0      12'h204
`define MQC_OFS_PTR_LAST  12'h220
`define MQC_OFS_IN_PORT   12'h040
`define MQC_OFS_OUT_PORT  12'h044
`define MQC_OFS_IRQ_STAT  12'h050
`define MQC_OFS_IRQ_MASK  12'h054
`define MQC_BASE_HI       31
`define MQC_BASE_LO       20
`define MQC_PTR_HI        19
`define MQC_PTR_LO        2
`define MQC_EMPTY_LO      12
`define MQC_FULL_LO       8
`define MQC_SIZE_HI       6
`define MQC_SIZE_LO       4
`define MQC_BRO_BIT       1
`define MQC_DIS_BIT       0
`define MQC_SIZE_256      3'h0
`define MQC_SIZE_1K       3'h1
`define MQC_SIZE_4K       3'h2
`define MQC_SIZE_16K      3'h3
`define MQC_SIZE_64K      3'h4
`define MQC_ALL_ONES      32'hFFFFFFFF
`define MQC_IRQ_W         3
`endif

// File: mqc_pkg.sv
// types of the message queue control block
package mqc_pkg;
  typedef enum logic [0:0] {
    MQC_PH_IDLE = 1'b0,
    MQC_PH_DATA = 1'b1
  } mqc_phase_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic        sel;
  } mqc_aphase_t;

  typedef struct packed {
    logic [11:0] base;
    logic [2:0]  size;
    logic        bro;
    logic        dis;
  } mqc_ctrl_t;

  typedef logic [17:0] mqc_ptr_t;
endpackage : mqc_pkg

// File: mqc_ctrl.sv
// message queue control: ahb-lite register slave, queue pointers and flags
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mqc_params.svh"
module mqc_ctrl
  import mqc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic        irq
);

  // four queues of one size, each with its own pointers, so none need be adjacent
  // queue q: top pointer at index 2q, bottom at 2q+1
  // q0 inbound free, q1 inbound post, q2 outbound free, q3 outbound post
  localparam int NPTR = 8;

  // pointer step of one word is four bytes, wrapped inside the queue size
  function automatic mqc_ptr_t mqc_mask(input logic [2:0] code);
    unique case (code)
      `MQC_SIZE_256: mqc_mask = 18'h000FF;
      `MQC_SIZE_1K:  mqc_mask = 18'h003FF;
      `MQC_SIZE_4K:  mqc_mask = 18'h00FFF;
      `MQC_SIZE_16K: mqc_mask = 18'h03FFF;
      `MQC_SIZE_64K: mqc_mask = 18'h0FFFF;
      // reserved codes fall back to the largest queue so pointers stay sane
      default:       mqc_mask = 18'h0FFFF;
    endcase
  endfunction : mqc_mask

  function automatic mqc_ptr_t mqc_adv(input mqc_ptr_t p, input logic [2:0] code);
    mqc_ptr_t m;
    m = mqc_mask(code);
    mqc_adv = (p & ~m) | ((p + 18'h00001) & m);
  endfunction : mqc_adv

  // every entry is one 32-bit word, so pointers count words, not bytes
  function automatic logic [31:0] mqc_addr(input logic [11:0] b, input mqc_ptr_t p);
    mqc_addr = {b, p, 2'b00};
  endfunction : mqc_addr

  mqc_phase_t              ph_q;
  mqc_phase_t              ph_d;
  mqc_aphase_t             ap_q;
  mqc_aphase_t             ap_d;
  mqc_ctrl_t               ctrl_q;
  mqc_ctrl_t               ctrl_d;
  mqc_ptr_t                ptr_q [NPTR];
  mqc_ptr_t                ptr_d [NPTR];
  logic [`MQC_IRQ_W-1:0]   stat_q;
  logic [`MQC_IRQ_W-1:0]   stat_d;
  logic [`MQC_IRQ_W-1:0]   mask_q;
  logic [`MQC_IRQ_W-1:0]   ev;
  logic [31:0]             rdata;
  logic [31:0]             hrdata_q;
  logic                    hreadyout_q;
  logic                    irq_q;
  logic [3:0]              q_empty;
  logic [3:0]              q_full;
  logic [NPTR-1:0]         adv;
  mqc_ptr_t                ptr_nxt [NPTR];
  logic                    hresp_q;

  // transfer width is not decoded; the bus carries whole words only
  wire        take       = hsel & htrans[1] & hready;
  wire        dp         = (ph_q == MQC_PH_DATA) & ap_q.sel;
  wire        wr         = dp & ap_q.write;
  wire        rd         = dp & ~ap_q.write;
  wire [11:0] a          = ap_q.addr;
  wire        hit_ctrl   = (a == `MQC_OFS_CTRL);
  wire        hit_ptr    = (a >= `MQC_OFS_PTR0) && (a <= `MQC_OFS_PTR_LAST)
                           && (a[1:0] == 2'b00);
  wire [11:0] ptr_ofs    = a - `MQC_OFS_PTR0;
  wire [2:0]  ptr_idx    = ptr_ofs[4:2];
  wire        hit_in     = (a == `MQC_OFS_IN_PORT);
  wire        hit_out    = (a == `MQC_OFS_OUT_PORT);
  wire        hit_stat   = (a == `MQC_OFS_IRQ_STAT);
  wire        hit_mask   = (a == `MQC_OFS_IRQ_MASK);

  // write strobes, one per register, except wr_ptr, which serves all eight pointers
  wire        wr_ctrl    = wr & hit_ctrl;
  wire        wr_ptr     = wr & hit_ptr;
  wire        wr_stat    = wr & hit_stat;
  wire        wr_mask    = wr & hit_mask;
  wire        qport      = hit_in | hit_out;
  wire        q_open     = ~ctrl_q.dis;
  wire        in_push    = wr & hit_in & q_open;
  wire        in_pop     = rd & hit_in & q_open;
  wire        out_push   = wr & hit_out & q_open;
  wire        out_pop    = rd & hit_out & q_open;
  wire        in_push_ok = in_push & ~q_full[1];
  wire        in_pop_ok  = in_pop & ~q_empty[0];
  wire        out_push_ok = out_push & ~q_full[2];
  wire        out_pop_ok = out_pop & ~q_empty[3];
  wire        refused    = dp & qport
                           & ~(in_push_ok | in_pop_ok | out_push_ok | out_pop_ok);

  // entry addresses handed out by the two queue ports
  wire [31:0] in_entry   = mqc_addr(ctrl_q.base, ptr_q[1]);
  wire [31:0] out_entry  = mqc_addr(ctrl_q.base, ptr_q[7]);
  // with the bro option set, the bottom pointer of an emptied queue reads back as the sentinel, not as a stale offset
  wire        bot_ones   = ptr_idx[0] & ctrl_q.bro & q_empty[ptr_idx[2:1]];

  // next position of every pointer, shared by the full flags and the device steps
  genvar gp;
  generate
    for (gp = 0; gp < NPTR; gp++) begin : g_step
      assign ptr_nxt[gp] = mqc_adv(ptr_q[gp], ctrl_q.size);
    end
  endgenerate

  // flags are pure compares, so reset pointers of zero read empty, not full
  genvar gq;
  generate
    for (gq = 0; gq < 4; gq++) begin : g_flag
      assign q_empty[gq] = (ptr_q[2*gq] == ptr_q[2*gq+1]);
      assign q_full[gq]  = (ptr_nxt[2*gq] == ptr_q[2*gq+1]);
    end
  endgenerate

  // pointers the device owns; the others are only stepped by the host
  assign adv = {out_pop_ok, 2'b00, out_push_ok, 1'b0, in_push_ok, in_pop_ok, 1'b0};

  assign ph_d = take ? MQC_PH_DATA : MQC_PH_IDLE;
  assign ap_d = '{addr: haddr[11:0], write: hwrite, sel: take};

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.base = hwdata[`MQC_BASE_HI:`MQC_BASE_LO];
      ctrl_d.size = hwdata[`MQC_SIZE_HI:`MQC_SIZE_LO];
      ctrl_d.bro  = hwdata[`MQC_BRO_BIT];
      ctrl_d.dis  = hwdata[`MQC_DIS_BIT];
    end
  end

  // host writes win over a device step in the same cycle (cannot overlap anyway)
  always_comb begin
    for (int i = 0; i < NPTR; i++) begin
      ptr_d[i] = ptr_q[i];
      if (wr_ptr && ptr_idx == 3'(i)) begin
        ptr_d[i] = hwdata[`MQC_PTR_HI:`MQC_PTR_LO];
      end else if (adv[i]) begin
        ptr_d[i] = ptr_nxt[i];
      end
    end
  end

  // events: inbound post, outbound free, refused queue access
  assign ev = {refused, out_push_ok, in_push_ok};

  // a new event in the clearing cycle survives the write-one-to-clear
  assign stat_d = (stat_q & ~(wr_stat ? hwdata[`MQC_IRQ_W-1:0] : '0)) | ev;

  always_comb begin
    rdata = '0;
    if (hit_ctrl) begin
      rdata[`MQC_BASE_HI:`MQC_BASE_LO] = ctrl_q.base;
      rdata[`MQC_EMPTY_LO+3:`MQC_EMPTY_LO] =
        {q_empty[0], q_empty[1], q_empty[2], q_empty[3]};
      rdata[`MQC_FULL_LO+3:`MQC_FULL_LO] =
        {q_full[0], q_full[1], q_full[2], q_full[3]};
      rdata[`MQC_SIZE_HI:`MQC_SIZE_LO] = ctrl_q.size;
      rdata[`MQC_BRO_BIT] = ctrl_q.bro;
      rdata[`MQC_DIS_BIT] = ctrl_q.dis;
    end else if (hit_ptr) begin
      // base in the upper bits of every pointer register is read-only
      rdata = mqc_addr(ctrl_q.base, ptr_q[ptr_idx]);
      if (bot_ones) begin
        rdata = `MQC_ALL_ONES;
      end
    end else if (hit_in) begin
      // only entry addresses are handed out; the frame datapath sits elsewhere
      rdata = in_pop_ok ? in_entry
                        : `MQC_ALL_ONES;
    end else if (hit_out) begin
      rdata = out_pop_ok ? out_entry
                         : `MQC_ALL_ONES;
    end else if (hit_stat) begin
      rdata[`MQC_IRQ_W-1:0] = stat_q;
    end else if (hit_mask) begin
      rdata[`MQC_IRQ_W-1:0] = mask_q;
    end
  end

  // the phase marks the cycle in which the data of a taken transfer moves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= MQC_PH_IDLE;
    end else begin
      ph_q <= ph_d;
    end
  end

  // address phase kept for the data phase that follows it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
    end else begin
      ap_q <= ap_d;
    end
  end

  // one wait state: ready drops for the data phase, rises with the data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= ~take;
    end
  end

  // read data stands only in the cycle it is valid, zero otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else begin
      hrdata_q <= rd ? rdata : '0;
    end
  end

  // no transfer is refused on the bus itself, so the response stays okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  // reserved size codes are kept as written and read back unchanged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // every pointer resets to offset zero, so every queue starts empty
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NPTR; i++) begin
        ptr_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NPTR; i++) begin
        ptr_q[i] <= ptr_d[i];
      end
    end
  end

  // status bits are sticky; only a written one clears them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // mask has the same layout as the status bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= hwdata[`MQC_IRQ_W-1:0];
    end
  end

  // irq follows the status one cycle late, straight from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign irq       = irq_q;

endmodule : mqc_ctrl
`default_nettype wire

// File: mqc_ctrl_sva.sv
// checker for the message queue control register slave
`timescale 1ns/1ps
`default_nettype none
module mqc_ctrl_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq
);
  logic [11:0] adr_q, base_q;
  logic [2:0]  size_q;
  logic        ph_q, wr_q, bro_q, dis_q, fresh_q;
  wire         take = hsel && htrans[1] && hready;
  wire         rd   = ph_q && hreadyout && !wr_q;
  wire         ctl  = rd && adr_q == 12'h200;
  wire         upd  = ph_q && !hreadyout && wr_q;
  // shadow of the control fields, taken from the bus itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ph_q, wr_q, adr_q, base_q, size_q, bro_q, dis_q} <= '0;
      fresh_q <= 1'b1;
    end else begin
      ph_q <= take || (ph_q && !hreadyout);
      if (take) {adr_q, wr_q} <= {haddr[11:0], hwrite};
      if (upd) fresh_q <= 1'b0;
      if (upd && adr_q == 12'h200) {base_q, size_q, bro_q, dis_q} <=
          {hwdata[31:20], hwdata[6:4], hwdata[1:0]};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0) else $error("bad hresp");
  a_one_wait: assert property (take |=> !hreadyout ##1 hreadyout) else $error("bad wait");
  a_rdata_idle: assert property (!rd |-> hrdata == 32'h0) else $error("hrdata not zero");
  a_reset_flags: assert property (
    ctl && fresh_q |-> hrdata[15:8] == 8'hF0) else $error("bad reset flags");
  a_base_rdback: assert property (
    ctl |-> hrdata[31:20] == base_q) else $error("bad base");
  a_size_rdback: assert property (
    ctl |-> hrdata[6:4] == size_q) else $error("bad size");
  a_flag_excl: assert property (
    ctl |-> (hrdata[15:12] & hrdata[11:8]) == 4'h0) else $error("empty and full");
  a_ptr_base: assert property (
    rd && adr_q == 12'h204 |-> hrdata[31:20] == base_q && hrdata[1:0] == 2'h0)
    else $error("bad top pointer");
  a_bro_clear: assert property (
    rd && adr_q == 12'h208 && !bro_q |-> hrdata[1:0] == 2'h0) else $error("bad bottom");
  a_dis_ones: assert property (
    rd && dis_q && (adr_q == 12'h040 || adr_q == 12'h044) |-> hrdata == 32'hFFFFFFFF)
    else $error("port not closed");
endmodule : mqc_ctrl_sva
bind mqc_ctrl mqc_ctrl_sva mqc_ctrl_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .irq);
`default_nettype wire

// File: mqc_host.sv
// bus master model standing in for the local host
`timescale 1ns/1ps
`default_nettype none
module mqc_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
  end
  // no latency assumed: waits on hready, the bench watchdog ends a hang
  task automatic hold(output logic [31:0] r);
    logic ok;
    do begin
      @(negedge hclk);
      ok = hready;
      r = hrdata;
      @(posedge hclk);
    end while (ok !== 1'b1);
  endtask : hold
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 20'h00000, a};
    hold(r);
    htrans <= 2'h0;
    hwdata <= d;
    hold(r);
    hwdata <= ~d;
  endtask : xfer
endmodule : mqc_host
`default_nettype wire

// File: mqc_ctrl_tb.sv
// self-checking bench for the message queue control slave
`timescale 1ns/1ps
`default_nettype none
module mqc_ctrl_tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          bad_count = 0;
  int          samples_checked = 0;
  mqc_ctrl mqc_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .irq);
  mqc_host mqc_host_i (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata);
  always #50 hclk = ~hclk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    mqc_host_i.xfer(1'b1, a, d, r);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    mqc_host_i.xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rd
  task irq_is(input logic e);
    @(negedge hclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : irq_is
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
  initial begin
    logic [2:0] c;
    hclk = 1'b0;
    hresetn = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(12'h200, 32'h0000F000);
    rd(12'h300, 32'h0);
    // top one word short of a lap: full at every size
    for (int i = 0; i < 5; i++) begin
      c = i[2:0];
      wr(12'h200, {12'hABC, 13'h0, c, 4'h0});
      wr(12'h204, 32'((256 << (2 * i)) * 4 - 4));
      rd(12'h200, {12'hABC, 4'h0, 8'h78, 1'b0, c, 4'h0});
    end
    wr(12'h204, 32'h000003FC);
    rd(12'h200, 32'hABC07040);
    wr(12'h200, 32'hABC00000);
    wr(12'h204, 32'hFFF00014);
    wr(12'h208, 32'h000003FC);
    rd(12'h204, 32'hABC00014);
    rd(12'h040, 32'hABC003FC);
    rd(12'h208, 32'hABC00000);
    wr(12'h208, 32'h00000014);
    rd(12'h208, 32'hABC00014);
    wr(12'h200, 32'hABC00002);
    rd(12'h208, 32'hFFFFFFFF);
    wr(12'h208, 32'h0);
    rd(12'h208, 32'hABC00000);
    wr(12'h200, 32'hABC00001);
    rd(12'h040, 32'hFFFFFFFF);
    wr(12'h044, 32'h12345678);
    rd(12'h208, 32'hABC00000);
    rd(12'h214, 32'hABC00000);
    rd(12'h050, 32'h4);
    irq_is(1'b0);
    wr(12'h054, 32'h4);
    irq_is(1'b1);
    wr(12'h050, 32'h4);
    rd(12'h050, 32'h0);
    irq_is(1'b0);
    wr(12'h200, 32'hABC00000);
    rd(12'h040, 32'hABC00000);
    rd(12'h208, 32'hABC00004);
    summarize();
  end
endmodule : mqc_ctrl_tb
`default_nettype wire
